/* File: logic/sfc_cfg.svh */
// Offsets, field positions, reset values, character codes and timing counts of the serial port.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH
`define SFC_OFS_CTRL 8'h00
`define SFC_OFS_PROG 8'h04
`define SFC_OFS_DIV 8'h08
`define SFC_OFS_TXD 8'h0C
`define SFC_OFS_RXD 8'h10
`define SFC_OFS_STAT 8'h14
`define SFC_CTRL_422 0
`define SFC_CTRL_EIA 1
`define SFC_CTRL_STOP2 2
`define SFC_CTRL_SW 3
`define SFC_CTRL_AUTO 4
`define SFC_CTRL_LOAD 5
`define SFC_CTRL_PAUSE 6
`define SFC_ST_RXV 0
`define SFC_ST_RXERR 1
`define SFC_ST_OVR 2
`define SFC_ST_NOPROG 3
`define SFC_ST_TXBUSY 4
`define SFC_ST_TXFULL 5
`define SFC_ST_HELD 6
`define SFC_ST_LOAD 7
`define SFC_ST_CFGERR 8
`define SFC_ST_SEQ 9
`define SFC_ST_HSIN 10
`define SFC_CTRL_RST 7'h00
`define SFC_DIV_RST 16'h0364
`define SFC_CH_CR 8'h0D
`define SFC_CH_EOB 8'h0A
`define SFC_CH_EOF 8'h04
`define SFC_CH_NULL 8'h00
`define SFC_CH_XON 8'h11
`define SFC_CH_RON 8'h12
`define SFC_CH_XOFF 8'h13
`define SFC_CH_ROFF 8'h14
`define SFC_NULL_CNT 5'h0A
`define SFC_XOFF_ALLOW 3'h3
`define SFC_LABEL_LEN 5'h11
`define SFC_HDR_LEN 5'h1B
`define SFC_CLK_NS 10
`define SFC_WAIT_NS 1000000000
`endif

/* File: logic/sfc_pkg.sv */
// Types of the serial flow control port.
package sfc_pkg;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } sfc_rx_e;
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_NULLS = 2'b01,
    SEQ_WAIT  = 2'b10,
    SEQ_HDR   = 2'b11
  } sfc_seq_e;
  typedef struct packed {
    logic        ph_act;
    logic        ph_wr;
    logic [7:0]  ph_addr;
    logic [31:0] hrdata;
    logic [6:0]  ctrl;
    logic [31:0] prog;
    logic [15:0] div;
    logic        rxd_s1;
    logic        rxd_s2;
    logic        hs_s1;
    logic        hs_s2;
    logic        tx_busy;
    logic        tx_line;
    logic [11:0] tx_sh;
    logic [3:0]  tx_bits;
    logic [15:0] tx_cnt;
    logic [7:0]  txbuf;
    logic        txbuf_full;
    sfc_rx_e     rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_bits;
    logic [15:0] rx_cnt;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_err;
    logic        xoff_rcvd;
    logic        pause_sent;
    logic [2:0]  after_cnt;
    logic        overrun;
    sfc_seq_e    seq;
    logic [4:0]  seq_idx;
    logic [31:0] wait_cnt;
    logic        load_active;
    logic        first_rx;
    logic        no_prog;
  } sfc_state_s;
endpackage

/* File: logic/sfc_port.sv */
// Serial port with line or in-band flow control and download request, AHB-Lite registers.
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module sfc_port #(
  parameter int unsigned WAIT_CYCLES = `SFC_WAIT_NS / `SFC_CLK_NS
) (
  input  logic        sys_clk,
  input  logic        reset_n,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  output logic        txd,
  input  logic        rxd,
  output logic        ctl_out,
  input  logic        status_in,
  output logic        line_mode_422
);

  sfc_pkg::sfc_state_s q;
  sfc_pkg::sfc_state_s n;

  logic        sw_eff;
  logic        fmt_eia;
  logic        can_data;
  logic        rx_done;
  logic        rx_good;
  logic [7:0]  rc;
  logic [7:0]  tx_char;
  logic        tx_go;

  // Start bit, payload with parity, then three stop-level bits (two in EIA format); the bit count trims the stops.
  function automatic logic [11:0] tx_frame(input logic [7:0] c, input logic eia);
    if (eia) begin
      tx_frame = {2'b11, ~(^c), c, 1'b0};
    end else begin
      tx_frame = {3'b111, ^c[6:0], c[6:0], 1'b0};
    end
  endfunction

  function automatic logic [3:0] frame_bits(input logic eia, input logic stop2);
    frame_bits = 4'hA + {3'h0, eia} + {3'h0, stop2};
  endfunction

  // Request header: label, eight BCD digits of the program number, CR, end-of-block.
  function automatic logic [7:0] hdr_char(input logic [4:0] i, input logic [31:0] p);
    logic [135:0] lbl;
    logic [4:0]   k;
    lbl = "DOWNLOAD PROGRAM:";
    k = i - `SFC_LABEL_LEN;
    if (i < `SFC_LABEL_LEN) begin
      hdr_char = lbl[135 - 8 * i -: 8];
    end else if (k < 5'h08) begin
      hdr_char = {4'h3, p[31 - 4 * k -: 4]};
    end else if (k == 5'h08) begin
      hdr_char = `SFC_CH_CR;
    end else begin
      hdr_char = `SFC_CH_EOB;
    end
  endfunction

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = q.hrdata;
  assign txd           = q.tx_line;
  assign line_mode_422 = q.ctrl[`SFC_CTRL_422];
  // The handshake output only exists in RS-232 line handshaking; otherwise it stays asserted.
  assign ctl_out       = sw_eff | ~q.ctrl[`SFC_CTRL_PAUSE];

  always_comb begin
    n        = q;
    sw_eff   = q.ctrl[`SFC_CTRL_SW] | q.ctrl[`SFC_CTRL_422];
    fmt_eia  = q.ctrl[`SFC_CTRL_EIA] & ~sw_eff;
    // is the remote side's duty; in software mode the input is simply not consulted.
    can_data = sw_eff ? ~q.xoff_rcvd : q.hs_s2;
    rx_done  = 1'b0;
    rx_good  = 1'b0;
    rc       = 8'h00;
    tx_char  = 8'h00;
    tx_go    = 1'b0;

    n.rxd_s1 = rxd;
    n.rxd_s2 = q.rxd_s1;
    n.hs_s1  = status_in;
    n.hs_s2  = q.hs_s1;

    // Address phase: read data is captured here so that it leaves a flip-flop.
    n.ph_act = hsel & hready & htrans[1];
    n.ph_wr  = hsel & hready & htrans[1] & hwrite;
    n.ph_addr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `SFC_OFS_CTRL: n.hrdata = {25'h0, q.ctrl};
        `SFC_OFS_PROG: n.hrdata = q.prog;
        `SFC_OFS_DIV:  n.hrdata = {16'h0, q.div};
        `SFC_OFS_RXD: begin
          n.hrdata   = {24'h0, q.rx_data};
          n.rx_valid = 1'b0;
        end
        `SFC_OFS_STAT: begin
          n.hrdata = 32'h0;
          n.hrdata[`SFC_ST_RXV]    = q.rx_valid;
          n.hrdata[`SFC_ST_RXERR]  = q.rx_err;
          n.hrdata[`SFC_ST_OVR]    = q.overrun;
          n.hrdata[`SFC_ST_NOPROG] = q.no_prog;
          n.hrdata[`SFC_ST_TXBUSY] = q.tx_busy;
          n.hrdata[`SFC_ST_TXFULL] = q.txbuf_full;
          n.hrdata[`SFC_ST_HELD]   = q.xoff_rcvd;
          n.hrdata[`SFC_ST_LOAD]   = q.load_active;
          n.hrdata[`SFC_ST_CFGERR] = q.ctrl[`SFC_CTRL_EIA] & sw_eff;
          n.hrdata[`SFC_ST_SEQ]    = q.seq != sfc_pkg::SEQ_IDLE;
          n.hrdata[`SFC_ST_HSIN]   = q.hs_s2;
        end
        default: n.hrdata = 32'h0;
      endcase
    end

    // Data phase of a write.
    if (q.ph_wr) begin
      case (q.ph_addr)
        `SFC_OFS_CTRL: begin
          n.ctrl = hwdata[6:0] & ~(7'h01 << `SFC_CTRL_LOAD);
          if (hwdata[`SFC_CTRL_LOAD]) begin
            n.load_active = 1'b1;
            n.first_rx    = 1'b1;
            n.no_prog     = 1'b0;
            n.overrun     = 1'b0;
            n.seq_idx     = 5'h00;
            n.seq = hwdata[`SFC_CTRL_AUTO] ? sfc_pkg::SEQ_NULLS : sfc_pkg::SEQ_IDLE;
          end
        end
        `SFC_OFS_PROG: n.prog = hwdata;
        `SFC_OFS_DIV:  n.div = (hwdata[15:0] < 16'h0002) ? 16'h0002 : hwdata[15:0];
        `SFC_OFS_TXD: begin
          if (!q.txbuf_full) begin
            n.txbuf      = hwdata[7:0];
            n.txbuf_full = 1'b1;
          end
        end
        `SFC_OFS_STAT: begin
          if (hwdata[`SFC_ST_RXERR])  n.rx_err  = 1'b0;
          if (hwdata[`SFC_ST_OVR])    n.overrun = 1'b0;
          if (hwdata[`SFC_ST_NOPROG]) n.no_prog = 1'b0;
        end
        default: ;
      endcase
    end

    // One-second pause of the request sequence.
    if (q.seq == sfc_pkg::SEQ_WAIT) begin
      if (q.wait_cnt >= WAIT_CYCLES - 1) begin
        n.seq      = sfc_pkg::SEQ_HDR;
        n.seq_idx  = 5'h00;
        n.wait_cnt = 32'h0;
      end else begin
        n.wait_cnt = q.wait_cnt + 32'h1;
      end
    end

    // Transmitter: only an idle line takes a new character, so XOFF never cuts one short.
    if (q.tx_busy) begin
      if (q.tx_cnt == 16'h0) begin
        n.tx_bits = q.tx_bits - 4'h1;
        if (q.tx_bits == 4'h1) begin
          n.tx_busy = 1'b0;
          n.tx_line = 1'b1;
        end else begin
          n.tx_sh   = {1'b1, q.tx_sh[11:1]};
          n.tx_line = q.tx_sh[1];
          n.tx_cnt  = q.div - 16'h1;
        end
      end else begin
        n.tx_cnt = q.tx_cnt - 16'h1;
      end
    end else if (sw_eff && (q.ctrl[`SFC_CTRL_PAUSE] != q.pause_sent)) begin
      tx_go        = 1'b1;
      tx_char      = q.ctrl[`SFC_CTRL_PAUSE] ? `SFC_CH_XOFF : `SFC_CH_XON;
      n.pause_sent = q.ctrl[`SFC_CTRL_PAUSE];
      n.after_cnt  = 3'h0;
    end else if (can_data && (q.seq == sfc_pkg::SEQ_NULLS)) begin
      tx_go     = 1'b1;
      tx_char   = `SFC_CH_NULL;
      n.seq_idx = q.seq_idx + 5'h01;
      if (q.seq_idx == `SFC_NULL_CNT - 5'h01) begin
        n.seq      = sfc_pkg::SEQ_WAIT;
        n.wait_cnt = 32'h0;
      end
    end else if (can_data && (q.seq == sfc_pkg::SEQ_HDR)) begin
      tx_go     = 1'b1;
      tx_char   = hdr_char(q.seq_idx, q.prog);
      n.seq_idx = q.seq_idx + 5'h01;
      if (q.seq_idx == `SFC_HDR_LEN - 5'h01) begin
        n.seq = sfc_pkg::SEQ_IDLE;
      end
    end else if (can_data && q.txbuf_full) begin
      tx_go        = 1'b1;
      tx_char      = q.txbuf;
      n.txbuf_full = 1'b0;
    end
    if (tx_go) begin
      n.tx_busy = 1'b1;
      n.tx_sh   = tx_frame(tx_char, fmt_eia);
      n.tx_line = 1'b0;
      n.tx_bits = frame_bits(fmt_eia, q.ctrl[`SFC_CTRL_STOP2]);
      n.tx_cnt  = q.div - 16'h1;
    end

    // Receiver: start bit checked at mid-bit, then one sample per bit time.
    case (q.rx_st)
      sfc_pkg::RX_IDLE: begin
        if (!q.rxd_s2) begin
          n.rx_st  = sfc_pkg::RX_START;
          n.rx_cnt = {1'b0, q.div[15:1]};
        end
      end
      sfc_pkg::RX_START: begin
        if (q.rx_cnt != 16'h0) begin
          n.rx_cnt = q.rx_cnt - 16'h1;
        end else if (q.rxd_s2) begin
          n.rx_st = sfc_pkg::RX_IDLE;
        end else begin
          n.rx_st   = sfc_pkg::RX_DATA;
          n.rx_cnt  = q.div - 16'h1;
          n.rx_bits = 4'h0;
        end
      end
      sfc_pkg::RX_DATA: begin
        if (q.rx_cnt != 16'h0) begin
          n.rx_cnt = q.rx_cnt - 16'h1;
        end else begin
          n.rx_sh   = {q.rxd_s2, q.rx_sh[8:1]};
          n.rx_bits = q.rx_bits + 4'h1;
          n.rx_cnt  = q.div - 16'h1;
          if (q.rx_bits == (fmt_eia ? 4'h8 : 4'h7)) begin
            n.rx_st = sfc_pkg::RX_STOP;
          end
        end
      end
      sfc_pkg::RX_STOP: begin
        if (q.rx_cnt != 16'h0) begin
          n.rx_cnt = q.rx_cnt - 16'h1;
        end else begin
          n.rx_st = sfc_pkg::RX_IDLE;
          rx_done = 1'b1;
          if (fmt_eia) begin
            rc      = q.rx_sh[7:0];
            rx_good = q.rxd_s2 & (^q.rx_sh);
          end else begin
            rc      = {1'b0, q.rx_sh[7:1]};
            rx_good = q.rxd_s2 & ~(^q.rx_sh[8:1]);
          end
        end
      end
      default: n.rx_st = sfc_pkg::RX_IDLE;
    endcase

    // Received characters; hardware sets win over register clears made above.
    if (rx_done && !rx_good) begin
      n.rx_err = 1'b1;
    end else if (rx_done && sw_eff && (rc == `SFC_CH_XOFF)) begin
      n.xoff_rcvd = 1'b1;
    end else if (rx_done && sw_eff && (rc == `SFC_CH_XON)) begin
      n.xoff_rcvd = 1'b0;
    end else if (rx_done && sw_eff && ((rc == `SFC_CH_RON) || (rc == `SFC_CH_ROFF))) begin
      n.rx_err = q.rx_err;
    end else if (rx_done) begin
      n.rx_data  = rc;
      n.rx_valid = 1'b1;
      n.first_rx = 1'b0;
      if (sw_eff && q.pause_sent) begin
        if (q.after_cnt == `SFC_XOFF_ALLOW) begin
          n.overrun     = 1'b1;
          n.load_active = 1'b0;
          n.seq         = sfc_pkg::SEQ_IDLE;
        end else begin
          n.after_cnt = q.after_cnt + 3'h1;
        end
      end
      if (q.load_active && (rc == `SFC_CH_EOF)) begin
        n.load_active = 1'b0;
        n.no_prog     = q.first_rx;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q         <= '0;
      q.ctrl    <= `SFC_CTRL_RST;
      q.div     <= `SFC_DIV_RST;
      q.rxd_s1  <= 1'b1;
      q.rxd_s2  <= 1'b1;
      q.tx_line <= 1'b1;
      q.rx_st   <= sfc_pkg::RX_IDLE;
      q.seq     <= sfc_pkg::SEQ_IDLE;
    end else begin
      q <= n;
    end
  end

endmodule

/* File: dv/sfc_port_asserts.sv */
// Concurrent checks on the bus, handshake and line ports of the serial port.
`timescale 1ns/100ps
module sfc_port_asserts (
  input logic        sys_clk,
  input logic        reset_n,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  input logic        txd,
  input logic        ctl_out,
  input logic        line_mode_422
);
  logic       wc_q;
  logic       ru_q;
  logic [6:0] ctrl_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Shadow of the control word, so the handshake output can be judged.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wc_q   <= 1'b0;
      ru_q   <= 1'b0;
      ctrl_q <= 7'h00;
    end else begin
      wc_q <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
      ru_q <= hsel & hready & htrans[1] & !hwrite & (haddr[7:0] > 8'h14);
      if (wc_q)
        ctrl_q <= hwdata[6:0];
    end
  end
  AST_READY: assert property (hreadyout) else $error("wait state inserted");
  AST_OKAY: assert property (!hresp) else $error("error response");
  AST_UNMAP: assert property (ru_q |-> hrdata == 32'h00000000) else $error("unmapped read");
  AST_MODE: assert property (wc_q |=> line_mode_422 == $past(hwdata[0]))
    else $error("line mode not taken");
  AST_HS422: assert property (line_mode_422 |-> ctl_out)
    else $error("handshake used in differential mode");
  AST_HSOUT: assert property (ctl_out == !(ctrl_q[6] & !ctrl_q[3] & !ctrl_q[0]))
    else $error("handshake output wrong");
  AST_LOWBIT: assert property ($fell(txd) |-> (!txd)[*8])
    else $error("low bit too short");
  AST_HIGHBIT: assert property ($rose(txd) |-> txd[*8])
    else $error("high bit too short");
  cover property ($fell(txd));
  cover property (!ctl_out);
  cover property (wc_q && hwdata[0]);
endmodule
bind sfc_port sfc_port_asserts u_chk (
  .sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .txd, .ctl_out, .line_mode_422
);

/* File: dv/sfc_host_model.sv */
// Remote host model: frame receiver, frame sender and handshake line.
`timescale 1ns/100ps
module sfc_host_model #(
  parameter int BIT = 8
) (
  input  logic sys_clk,
  input  logic txd,
  output logic rxd,
  output logic status_in
);
  logic [8:0] got[$];
  logic       held;
  initial begin
    rxd       = 1'b1;
    status_in = 1'b1;
    held      = 1'b0;
  end
  // Nine samples cover seven data bits, parity and stop, or eight data bits and parity.
  always begin : rx_frame
    logic [8:0] w;
    @(negedge txd);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge sys_clk);
      w[i] = txd;
    end
    got.push_back(w);
    if (w[7:0] == 8'h93)
      held = 1'b1;
    if (w[7:0] == 8'h11)
      held = 1'b0;
  end
  // Sending past a pause happens when the caller asks for it or after 20000 cycles of waiting.
  task send(input logic [8:0] w, input logic ign);
    int k;
    k = 0;
    while (held && !ign && k < 20000) begin
      k++;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= w[i];
      repeat (BIT) @(posedge sys_clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge sys_clk);
  endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the serial flow control port.
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module tb_top;
  logic        sys_clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        txd;
  logic        rxd;
  logic        ctl_out;
  logic        status_in;
  logic        lm422;
  logic [31:0] r;
  int          n_errors;
  int          checks_done;
  string       s;
  sfc_port #(.WAIT_CYCLES(20)) dut (
    .sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata, .txd, .rxd, .ctl_out, .status_in,
    .line_mode_422(lm422)
  );
  sfc_host_model #(.BIT(8)) u_host (.sys_clk, .txd, .rxd, .status_in);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tmo;
    n_errors++;
    $display("[ERR] %0t wait timed out", $time);
    finish_test;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 50)
        tmo;
      @(posedge sys_clk);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    acc(1'b0, a, 32'h00000000);
    q = hrdata;
  endtask
  task gc(input logic [8:0] e);
    int k;
    k = 0;
    while (u_host.got.size() == 0) begin
      k++;
      if (k > 4000)
        tmo;
      @(posedge sys_clk);
    end
    chk({23'h000000, u_host.got.pop_front()}, {23'h000000, e});
  endtask
  function automatic logic [8:0] fa(input logic [6:0] c);
    return {1'b1, ^c, c};
  endfunction
  task t_regs;
    rd(`SFC_OFS_CTRL, r);
    chk(r, 32'h00000000);
    rd(`SFC_OFS_DIV, r);
    chk(r, 32'h00000364);
    rd(`SFC_OFS_STAT, r);
    chk(r, 32'h00000400);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, r);
    chk(r, 32'h00000000);
    wr(`SFC_OFS_DIV, 32'h00000008);
  endtask
  task t_tx;
    logic [6:0] c[4];
    c = '{7'h0D, 7'h0A, 7'h04, 7'h00};
    foreach (c[i]) begin
      wr(`SFC_OFS_TXD, {25'h0000000, c[i]});
      gc(fa(c[i]));
    end
    wr(`SFC_OFS_CTRL, 32'h00000006);
    wr(`SFC_OFS_TXD, 32'h000000A5);
    gc({~^8'hA5, 8'hA5});
    wr(`SFC_OFS_CTRL, 32'h00000000);
  endtask
  task t_rx;
    u_host.send(9'h041, 1'b1);
    rd(`SFC_OFS_STAT, r);
    chk(r & 32'h00000001, 32'h00000001);
    rd(`SFC_OFS_RXD, r);
    chk(r, 32'h00000041);
  endtask
  task t_hw;
    u_host.status_in <= 1'b0;
    wr(`SFC_OFS_TXD, 32'h00000043);
    repeat (200) @(posedge sys_clk);
    chk(u_host.got.size(), 32'h00000000);
    u_host.status_in <= 1'b1;
    gc(fa(7'h43));
    wr(`SFC_OFS_CTRL, 32'h00000040);
    @(posedge sys_clk);
    chk({31'h00000000, ctl_out}, 32'h00000000);
    wr(`SFC_OFS_CTRL, 32'h00000001);
    @(posedge sys_clk);
    chk({30'h00000000, lm422, ctl_out}, 32'h00000003);
    wr(`SFC_OFS_CTRL, 32'h00000008);
  endtask
  task t_sw;
    fork
      u_host.send(9'h093, 1'b1);
      begin
        repeat (40) @(posedge sys_clk);
        wr(`SFC_OFS_TXD, 32'h00000055);
      end
    join
    gc(fa(7'h55));
    wr(`SFC_OFS_TXD, 32'h0000002A);
    repeat (200) @(posedge sys_clk);
    chk(u_host.got.size(), 32'h00000000);
    u_host.send(9'h011, 1'b1);
    gc(fa(7'h2A));
  endtask
  task t_ovr;
    wr(`SFC_OFS_CTRL, 32'h00000028);
    wr(`SFC_OFS_CTRL, 32'h00000048);
    gc(fa(7'h13));
    for (int i = 0; i < 4; i++) begin
      u_host.send(fa(7'(i + 48)), 1'b1);
      rd(`SFC_OFS_STAT, r);
      chk(r & 32'h00000084, (i < 3) ? 32'h00000080 : 32'h00000004);
    end
    wr(`SFC_OFS_CTRL, 32'h00000008);
    gc(fa(7'h11));
    wr(`SFC_OFS_CTRL, 32'h0000000A);
    rd(`SFC_OFS_STAT, r);
    chk(r & 32'h00000100, 32'h00000100);
  endtask
  task t_auto;
    s = "DOWNLOAD PROGRAM:12345678\r\n";
    wr(`SFC_OFS_CTRL, 32'h00000000);
    wr(`SFC_OFS_PROG, 32'h12345678);
    wr(`SFC_OFS_CTRL, 32'h00000030);
    repeat (10) gc(fa(7'h00));
    for (int i = 0; i < 27; i++)
      gc(fa(7'(s[i])));
    u_host.send(9'h084, 1'b0);
    rd(`SFC_OFS_STAT, r);
    chk(r & 32'h00000088, 32'h00000008);
  endtask
  initial begin
    reset_n     = 1'b0;
    hsel        = 1'b1;
    haddr       = 32'h00000000;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h00000000;
    n_errors    = 0;
    checks_done = 0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_tx;
    t_rx;
    t_hw;
    t_sw;
    t_ovr;
    t_auto;
    finish_test;
  end
endmodule
